//--- hdl/cmas_core.sv
// Address decode and stack logic for the core: branch targets, program and
// data memory maps, bank registers, bit addressing, stack pointer and record.
// Assumes the execution unit on the same ref_clk drives one request per cycle.
//
// Summary of operation
// - Relative target is next-instruction address plus signed 8-bit displacement.
// - Direct address below 0x80 hits RAM, 0x80 and above hits special registers.
// - Absolute target keeps upper five bits of next address, eleven from operand.
// - Long call and jump use the full 16-bit target.
// - Spare opcode 0xA5 is executed as a no-operation.
// - Program storage spans 0x0000 to 0x807F contiguously.
// - Range 0x7E00 to 0x7FFF is reserved and refused to user accesses.
// - Program store control bit 7 lets external data writes hit program memory.
// - 256 bytes of data RAM, separate from special register space.
// - Lower 128 bytes reachable both directly and indirectly.
// - Above 0x7F, direct goes to special registers, indirect to upper RAM.
// - Bytes 0x00 to 0x1F are four banks, selected by status word bits 3-4.
// - Indirect pointer comes from register 0 or 1 of active bank.
// - Bytes 0x20 to 0x2F give 128 bits, address eight times offset plus bit.
// - Bit or byte access chosen only by the instruction operand type.
// - Stack pointer at 0x81 holds last used; push writes pointer plus one.
// - Reset sets stack pointer to 0x07, first push lands at 0x08.
// - Record register shifts in one bit per push or increment, two per call.
// - Record shifts out one bit per pop or decrement, two per return.
// - Record overflow and underflow are flagged to emulation logic.
// - Only special registers at addresses ending 0 or 8 allow bit access.
`timescale 1ns/1ps
`default_nettype none

module cmas_core
    import cmas_pkg::*;
#(
    parameter int RAM_DEPTH = 256
) (
    input  wire logic          ref_clk,
    input  wire logic          rst_n,
    input  wire logic          clk_en,
    // Branch target calculation
    input  wire cmas_jmp_t     jmp_kind,
    input  wire logic [15:0]   next_pc,
    input  wire logic [15:0]   jmp_operand,
    output logic [15:0]        jmp_target,
    // Opcode screening
    input  wire logic [7:0]    opcode_in,
    output logic [7:0]         opcode_out,
    // Program memory access check
    input  wire logic [15:0]   prog_addr,
    input  wire logic          prog_user,
    input  wire logic          ext_move_wr,
    output logic               prog_hit,
    output logic               prog_wr_en,
    // Data memory access
    input  wire cmas_dreq_t    dreq,
    output logic [7:0]         drdata,
    output logic               dbit,
    output logic               sfr_sel,
    output logic [7:0]         sfr_addr,
    output logic               sfr_bit_ok,
    input  wire logic [7:0]    sfr_rdata,
    // Stack
    input  wire cmas_stk_req_t stk,
    input  wire logic [7:0]    push_data,
    output logic [7:0]         pop_data,
    output logic [7:0]         stack_pointer,
    output logic               rec_overflow,
    output logic               rec_underflow
);

    logic [7:0]            ram [RAM_DEPTH];
    logic [7:0]            stack_pointer_r;
    logic [7:0]            stack_pointer_nxt;
    logic [7:0]            program_status_word_r;
    logic [7:0]            program_store_control_r;
    logic [CMAS_REC_W-1:0] rec_r;
    logic [CMAS_REC_W-1:0] rec_nxt;
    logic [5:0]            rec_cnt_r;
    logic [5:0]            rec_cnt_nxt;
    logic                  ovf_r;
    logic                  unf_r;
    logic [7:0]            drdata_r;
    logic                  dbit_r;
    logic [7:0]            pop_data_r;
    logic [7:0]            opcode_r;
    logic [15:0]           target_r;

    // Target arithmetic is kept apart from the
    // sequencing so that the execution unit can
    // hand over the next-instruction address and
    // the raw operand in one cycle. The result is
    // registered, so the unit sees it one enabled
    // edge later. The relative form sign-extends
    // the low operand byte. The absolute form
    // keeps the page bits of the next address.
    // Hazard: a caller that passes the address of
    // the branch itself gets the wrong page.
    // Branch targets
    wire [15:0] rel_target  = next_pc + {{8{jmp_operand[7]}}, jmp_operand[7:0]};
    wire [15:0] abs_target  = {next_pc[15:11], jmp_operand[10:0]};
    wire [15:0] long_target = jmp_operand;
    wire [15:0] target_sel  = (jmp_kind == CMAS_JMP_REL)  ? rel_target  :
                              (jmp_kind == CMAS_JMP_ABS)  ? abs_target  :
                              (jmp_kind == CMAS_JMP_LONG) ? long_target : next_pc;

    // Spare opcode folded onto the plain no-operation
    wire [7:0] opcode_sel = (opcode_in == CMAS_OP_SPARE_NOP) ? CMAS_OP_NOP : opcode_in;

    // Map checks are purely combinational so
    // the fetch path can use them in the same
    // cycle as the address. Only user accesses
    // are kept out of the reserved range; an
    // internal access still reaches it. Writes
    // need both the external data move and the
    // enable bit, so a stray move cannot alter
    // program storage by accident.
    // Program memory map; reserved range is hidden from user accesses
    wire prog_in_range = (prog_addr <= CMAS_PROG_TOP);
    wire prog_reserved = (prog_addr >= CMAS_RSV_LO) && (prog_addr <= CMAS_RSV_HI);
    assign prog_hit    = prog_in_range && !(prog_user && prog_reserved);
    assign prog_wr_en  = ext_move_wr && prog_hit
                         && program_store_control_r[CMAS_PROGRAM_STORE_CONTROL_WE_BIT];

    // Bank selection comes straight from the
    // status word register, so a bank switch is
    // seen by the very next request. The two
    // pointer registers are read through the
    // same bank, which keeps indirect accesses
    // consistent with bank register operands.
    // Limitation: the pointer read is a second
    // RAM read port in the same cycle.
    // Active bank and register addressing
    wire [1:0] bank_sel   = program_status_word_r[CMAS_PSW_RS0_BIT +: 2];
    wire [7:0] bank_addr  = {3'h0, bank_sel, dreq.reg_idx};
    wire [7:0] ptr_addr   = {3'h0, bank_sel, 2'h0, dreq.reg_idx[0]};
    wire [7:0] ind_addr   = ram[ptr_addr];

    // Bit operands below the midpoint address
    // the sixteen bit-capable RAM bytes; those
    // above it land on special registers whose
    // address ends in zero or eight. The low
    // three operand bits always give the bit
    // position inside the chosen byte.
    // Bit addresses: RAM region below 0x80, special registers above
    wire       bit_in_ram = (dreq.addr[7:0] <= {1'b0, CMAS_BITRAM_TOP});
    wire [7:0] bit_byte   = bit_in_ram ? (CMAS_BITRAM_BASE + {4'h0, dreq.addr[6:3]})
                                       : {dreq.addr[7:3], 3'h0};
    wire [2:0] bit_pos    = dreq.addr[2:0];

    // Priority among the address sources is
    // fixed: bank operand, then indirect, then
    // bit, then plain direct. The caller sets
    // only one of them; the fixed order keeps
    // the result defined when it does not.
    // Indirect accesses never reach the special
    // register space, whatever the address.
    // Byte address and space selection; operand type alone picks bit mode
    wire [7:0] byte_addr  = dreq.bank_reg ? bank_addr :
                            dreq.indirect ? ind_addr  :
                            dreq.bit_op   ? bit_byte  : dreq.addr;
    wire       to_sfr     = !dreq.indirect && !dreq.bank_reg
                            && (byte_addr > CMAS_LOWER_TOP);
    assign sfr_sel    = dreq.valid && to_sfr;
    assign sfr_addr   = byte_addr;
    assign sfr_bit_ok = (byte_addr[2:0] == CMAS_SFR_BIT_LOW);

    // The core keeps three special registers of
    // its own; every other special address is
    // passed to the outside register file and
    // its read data is taken in the same cycle.
    // A bit write becomes read-modify-write of
    // the whole byte, so other bits survive;
    // a bit write to the stack pointer is dropped.
    // Core-owned special registers
    wire own_sp    = to_sfr && (byte_addr == CMAS_SP_ADDR);
    wire own_psw   = to_sfr && (byte_addr == CMAS_PSW_ADDR);
    wire own_program_store_control = to_sfr && (byte_addr == CMAS_PROGRAM_STORE_CONTROL_ADDR);
    wire [7:0] rd_byte = !to_sfr  ? ram[byte_addr] :
                         own_sp   ? stack_pointer_r :
                         own_psw  ? program_status_word_r :
                         own_program_store_control ? program_store_control_r : sfr_rdata;
    wire       wr      = dreq.valid && dreq.write;
    wire [7:0] wr_byte = dreq.bit_op ? ((rd_byte & ~(8'h01 << bit_pos))
                                        | ({7'h00, dreq.wdata[0]} << bit_pos))
                                     : dreq.wdata;

    // A byte write to the pointer wins over any
    // stack operation in the same cycle, so
    // software can always reposition the stack.
    // Calls and returns move by two bytes, one
    // for each half of the return address.
    // Wrapping is deliberate: the stack may
    // span all of data memory, and no limit is
    // enforced here; the record flags misuse.
    // Stack pointer: push pre-increments, pop post-decrements, both wrap
    wire do_up   = stk.push || stk.sp_inc || stk.call;
    wire do_down = stk.pop || stk.sp_dec || stk.ret;
    wire [7:0] push_addr = stack_pointer_r + 8'h01;
    always_comb begin
        stack_pointer_nxt = stack_pointer_r;
        if (wr && own_sp && !dreq.bit_op) begin
            stack_pointer_nxt = wr_byte;
        end else if (stk.call) begin
            stack_pointer_nxt = stack_pointer_r + 8'h02;
        end else if (stk.ret) begin
            stack_pointer_nxt = stack_pointer_r - 8'h02;
        end else if (stk.push || stk.sp_inc) begin
            stack_pointer_nxt = push_addr;
        end else if (stk.pop || stk.sp_dec) begin
            stack_pointer_nxt = stack_pointer_r - 8'h01;
        end
    end

    // The record keeps one mark per byte-wide
    // stack move and two per call or return.
    // A depth counter beside the shifter is
    // cheaper than scanning the shifter and
    // saturates at both ends, so one bad
    // sequence is flagged once per event and
    // does not wrap into a false normal depth.
    // Stack record shifter; counter tracks depth to spot over and underflow
    always_comb begin
        rec_nxt     = rec_r;
        rec_cnt_nxt = rec_cnt_r;
        if (stk.call) begin
            rec_nxt     = {rec_r[CMAS_REC_W-3:0], 2'b11};
            rec_cnt_nxt = (rec_cnt_r >= CMAS_REC_FULL - 6'h01) ? CMAS_REC_FULL
                                                               : rec_cnt_r + 6'h02;
        end else if (stk.push || stk.sp_inc) begin
            rec_nxt     = {rec_r[CMAS_REC_W-2:0], 1'b0};
            rec_cnt_nxt = (rec_cnt_r == CMAS_REC_FULL) ? CMAS_REC_FULL
                                                       : rec_cnt_r + 6'h01;
        end else if (stk.ret) begin
            rec_nxt     = {2'b00, rec_r[CMAS_REC_W-1:2]};
            rec_cnt_nxt = (rec_cnt_r <= 6'h01) ? 6'h00 : rec_cnt_r - 6'h02;
        end else if (stk.pop || stk.sp_dec) begin
            rec_nxt     = {1'b0, rec_r[CMAS_REC_W-1:1]};
            rec_cnt_nxt = (rec_cnt_r == 6'h00) ? 6'h00 : rec_cnt_r - 6'h01;
        end
    end
    wire ovf_evt = (stk.call && (rec_cnt_r >= CMAS_REC_FULL - 6'h01))
                   || ((stk.push || stk.sp_inc) && !stk.call
                       && (rec_cnt_r == CMAS_REC_FULL));
    wire unf_evt = (stk.ret && (rec_cnt_r <= 6'h01))
                   || ((stk.pop || stk.sp_dec) && !stk.ret && !stk.call
                       && (rec_cnt_r == 6'h00));

    // All control state shares one enable so a
    // halted core keeps a coherent picture for
    // emulation. Over and underflow are single
    // cycle pulses; the emulation side must
    // catch them on the edge they appear.
    // Reset values are constants only.
    // Control state, frozen while clk_en is low
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            stack_pointer_r         <= CMAS_SP_RESET;
            program_status_word_r   <= 8'h00;
            program_store_control_r <= 8'h00;
            rec_r                   <= '0;
            rec_cnt_r               <= 6'h00;
            ovf_r                   <= 1'b0;
            unf_r                   <= 1'b0;
        end else if (clk_en) begin
            stack_pointer_r <= stack_pointer_nxt;
            rec_r           <= rec_nxt;
            rec_cnt_r       <= rec_cnt_nxt;
            ovf_r           <= ovf_evt;
            unf_r           <= unf_evt;
            if (wr && own_psw) begin
                program_status_word_r <= wr_byte;
            end
            if (wr && own_program_store_control) begin
                program_store_control_r <= wr_byte;
            end
        end
    end

    // Read data, popped byte, opcode and target
    // are all registered, trading one cycle of
    // latency for clean timing at the outputs.
    // The popped byte is sampled every enabled
    // cycle from the current pointer location.
    // Registered data outputs
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            drdata_r   <= 8'h00;
            dbit_r     <= 1'b0;
            pop_data_r <= 8'h00;
            opcode_r   <= CMAS_OP_NOP;
            target_r   <= 16'h0000;
        end else if (clk_en) begin
            drdata_r   <= rd_byte;
            dbit_r     <= rd_byte[bit_pos];
            pop_data_r <= ram[stack_pointer_r];
            opcode_r   <= opcode_sel;
            target_r   <= target_sel;
        end
    end

    // One write port only: a push takes the
    // port and a concurrent data write is lost.
    // The caller must not issue both at once.
    // Contents are undefined after power-up.
    // RAM has no reset; push and data writes may not coincide on one cycle
    always_ff @(posedge ref_clk) begin
        if (clk_en) begin
            if (stk.push) begin
                ram[push_addr] <= push_data;
            end else if (wr && !to_sfr) begin
                ram[byte_addr] <= wr_byte;
            end
        end
    end

    // Outputs are straight copies of registers
    // so no logic sits between flop and pin.
    assign drdata        = drdata_r;
    assign dbit          = dbit_r;
    assign pop_data      = pop_data_r;
    assign opcode_out    = opcode_r;
    assign jmp_target    = target_r;
    assign stack_pointer = stack_pointer_r;
    assign rec_overflow  = ovf_r;
    assign rec_underflow = unf_r;

endmodule

`default_nettype wire

//--- inc/cmas_pkg.sv
// Package for the core memory addressing and stack block.
// Holds address map constants, field positions and the operand carrier structs.
package cmas_pkg;

    // Data memory map
    localparam logic [7:0]  CMAS_LOWER_TOP     = 8'h7F;
    localparam logic [7:0]  CMAS_BANK_TOP      = 8'h1F;
    localparam logic [7:0]  CMAS_BITRAM_BASE   = 8'h20;
    localparam logic [7:0]  CMAS_SP_ADDR       = 8'h81;
    localparam logic [7:0]  CMAS_SP_RESET      = 8'h07;
    localparam logic [7:0]  CMAS_PROGRAM_STORE_CONTROL_ADDR    = 8'h8F;
    localparam logic [7:0]  CMAS_PSW_ADDR      = 8'hD0;
    localparam int          CMAS_PSW_RS0_BIT   = 3;
    localparam int          CMAS_PROGRAM_STORE_CONTROL_WE_BIT  = 7;
    localparam logic [2:0]  CMAS_SFR_BIT_LOW   = 3'h0;
    localparam logic [6:0]  CMAS_BITRAM_TOP    = 7'h7F;
    // Program memory map
    localparam logic [15:0] CMAS_PROG_TOP      = 16'h807F;
    localparam logic [15:0] CMAS_RSV_LO        = 16'h7E00;
    localparam logic [15:0] CMAS_RSV_HI        = 16'h7FFF;
    localparam logic [7:0]  CMAS_OP_SPARE_NOP  = 8'hA5;
    localparam logic [7:0]  CMAS_OP_NOP        = 8'h00;
    // Stack record
    localparam int          CMAS_REC_W         = 32;
    localparam logic [5:0]  CMAS_REC_FULL      = 6'h20;

    // Jump kinds
    typedef enum logic [1:0] {
        CMAS_JMP_REL  = 2'b00,
        CMAS_JMP_ABS  = 2'b01,
        CMAS_JMP_LONG = 2'b10,
        CMAS_JMP_NONE = 2'b11
    } cmas_jmp_t;

    // Stack operation request from the execution unit
    typedef struct packed {
        logic push;
        logic pop;
        logic sp_inc;
        logic sp_dec;
        logic call;
        logic ret;
    } cmas_stk_req_t;

    // Data access request
    typedef struct packed {
        logic       valid;
        logic       write;
        logic       indirect;
        logic       bank_reg;
        logic       bit_op;
        logic [2:0] reg_idx;
        logic [7:0] addr;
        logic [7:0] wdata;
    } cmas_dreq_t;

endpackage

//--- tb/cmas_core_monitor.sv
// Port-level checker for cmas_core, bound to every instance of it.
// Assumes one ref_clk domain and the active-low asynchronous rst_n.
`timescale 1ns/1ps
`default_nettype none
module cmas_core_monitor
    import cmas_pkg::*;
(
    input wire logic          ref_clk,
    input wire logic          rst_n,
    input wire logic          clk_en,
    input wire cmas_jmp_t     jmp_kind,
    input wire logic [15:0]   next_pc,
    input wire logic [15:0]   jmp_operand,
    input wire logic [15:0]   jmp_target,
    input wire logic [7:0]    opcode_in,
    input wire logic [7:0]    opcode_out,
    input wire logic [15:0]   prog_addr,
    input wire logic          prog_user,
    input wire logic          ext_move_wr,
    input wire logic          prog_hit,
    input wire logic          prog_wr_en,
    input wire cmas_dreq_t    dreq,
    input wire logic          sfr_sel,
    input wire logic [7:0]    sfr_addr,
    input wire logic          sfr_bit_ok,
    input wire cmas_stk_req_t stk,
    input wire logic [7:0]    push_data,
    input wire logic [7:0]    pop_data,
    input wire logic [7:0]    stack_pointer
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // Expected targets; stack checks only when no bus write can win
    wire logic [15:0] rel_tgt  = next_pc + {{8{jmp_operand[7]}}, jmp_operand[7:0]};
    wire logic [15:0] abs_tgt  = {next_pc[15:11], jmp_operand[10:0]};
    wire logic        quiet    = clk_en && !dreq.valid;
    wire logic        push_one = quiet && stk == 6'b100000;
    wire logic        pop_one  = quiet && stk == 6'b010000;

    a_sp_reset_val: assert property ($rose(rst_n) |-> stack_pointer == 8'h07)
        else $error("stack pointer wrong after reset");
    a_push_moves_sp: assert property (push_one |=> stack_pointer == $past(stack_pointer) + 8'h01)
        else $error("push did not step pointer up by one");
    a_pop_moves_sp: assert property (pop_one |=> stack_pointer == $past(stack_pointer) - 8'h01)
        else $error("pop did not step pointer down by one");
    a_push_pop_data: assert property (push_one ##1 pop_one |=> pop_data == $past(push_data, 2))
        else $error("pop did not return last pushed byte");
    a_spare_op_nop: assert property (clk_en && opcode_in == 8'hA5 |=> opcode_out == 8'h00)
        else $error("spare opcode not turned into no-op");
    a_rel_target: assert property (clk_en && jmp_kind == CMAS_JMP_REL |=> jmp_target == $past(rel_tgt))
        else $error("relative target wrong");
    a_abs_target: assert property (clk_en && jmp_kind == CMAS_JMP_ABS |=> jmp_target == $past(abs_tgt))
        else $error("absolute target wrong");
    a_rsv_refused: assert property (prog_user && prog_addr inside {[16'h7E00:16'h7FFF]} |-> !prog_hit)
        else $error("reserved program range accepted");
    a_prog_top: assert property (prog_user && prog_addr > 16'h807F |-> !prog_hit)
        else $error("program access beyond top accepted");
    a_write_needs_move: assert property (prog_wr_en |-> ext_move_wr)
        else $error("program write without external move");
    a_sfr_bit_addr: assert property (dreq.valid && dreq.bit_op && sfr_sel |-> sfr_bit_ok)
        else $error("bit access allowed on wrong register");
    a_indirect_ram: assert property (dreq.valid && dreq.indirect |-> !sfr_sel)
        else $error("indirect access reached special registers");

    c_push_pop: cover property (push_one ##1 pop_one);
    c_abs_jump: cover property (clk_en && jmp_kind == CMAS_JMP_ABS);
    c_prog_write: cover property (prog_wr_en);
endmodule

bind cmas_core cmas_core_monitor u_cmas_core_monitor (
    .ref_clk, .rst_n, .clk_en, .jmp_kind, .next_pc, .jmp_operand, .jmp_target,
    .opcode_in, .opcode_out, .prog_addr, .prog_user, .ext_move_wr, .prog_hit,
    .prog_wr_en, .dreq, .sfr_sel, .sfr_addr, .sfr_bit_ok, .stk, .push_data,
    .pop_data, .stack_pointer
);
`default_nettype wire

//--- tb/cmas_sfr_model.sv
// Stand-in for the outside special register file.
// Answers a selected read at once; unselected output churns every cycle.
`timescale 1ns/1ps
`default_nettype none
module cmas_sfr_model (
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    input  wire logic       sfr_sel,
    input  wire logic [7:0] sfr_addr,
    output logic [7:0]      sfr_rdata
);
    logic [7:0] churn_r;
    // Filler so a stale read never looks like real data
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n)
            churn_r <= 8'h5A;
        else
            churn_r <= ~churn_r + 8'h01;
    end
    // Register contents: address with nibbles swapped
    assign sfr_rdata = sfr_sel ? {sfr_addr[3:0], sfr_addr[7:4]} : churn_r;
endmodule
`default_nettype wire

//--- tb/cmas_core_tb.sv
// Self-checking bench for cmas_core with a special register file model.
// Assumes the checker binds itself; inputs change on the falling edge.
`timescale 1ns/1ps
`default_nettype none
module cmas_core_tb;
    import cmas_pkg::*;
    logic          ref_clk     = 1'b0;
    logic          rst_n       = 1'b0;
    logic          clk_en      = 1'b1;
    cmas_jmp_t     jmp_kind    = CMAS_JMP_NONE;
    logic [15:0]   next_pc     = 16'h0000;
    logic [15:0]   jmp_operand = 16'h0000;
    logic [15:0]   prog_addr   = 16'h0000;
    logic [7:0]    opcode_in   = 8'h00;
    logic          prog_user   = 1'b1;
    logic          ext_move_wr = 1'b0;
    cmas_dreq_t    dreq        = '0;
    cmas_stk_req_t stk         = '0;
    logic [7:0]    push_data   = 8'h00;
    logic [15:0]   jmp_target;
    logic [7:0]    opcode_out, drdata, sfr_addr, sfr_rdata, pop_data, stack_pointer, rd;
    logic          prog_hit, prog_wr_en, dbit, sfr_sel, sfr_bit_ok, rec_overflow, rec_underflow, sel;
    int            err_count   = 0;
    int            comparisons = 0;

    cmas_core u_cmas_core (
        .ref_clk, .rst_n, .clk_en, .jmp_kind, .next_pc, .jmp_operand, .jmp_target,
        .opcode_in, .opcode_out, .prog_addr, .prog_user, .ext_move_wr, .prog_hit,
        .prog_wr_en, .dreq, .drdata, .dbit, .sfr_sel, .sfr_addr, .sfr_bit_ok, .sfr_rdata,
        .stk, .push_data, .pop_data, .stack_pointer, .rec_overflow, .rec_underflow
    );
    cmas_sfr_model u_cmas_sfr_model (.ref_clk, .rst_n, .sfr_sel, .sfr_addr, .sfr_rdata);

    always #12.5 ref_clk = ~ref_clk;

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic tick;
        @(posedge ref_clk);
        @(negedge ref_clk);
    endtask
    task automatic end_sim;
        $display("Comparisons %0d, mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // Reset held for ten cycles; idle stack so release is clean
    task automatic reset_dut;
        rst_n = 1'b0;
        stk = '0;
        repeat (10) tick;
        rst_n = 1'b1;
    endtask
    // mode = {write, indirect, bank_reg, bit_op}; left valid, caller clears
    task automatic dacc(input logic [3:0] m, input logic [2:0] i, input logic [7:0] a, w);
        dreq = {1'b1, m, i, a, w};
        tick;
        sel = sfr_sel;
        rd = m[0] ? {7'h00, dbit} : drdata;
    endtask
    task automatic sop(input logic [5:0] s, input logic [7:0] d);
        stk = s;
        push_data = d;
        tick;
    endtask
    task automatic br(input cmas_jmp_t k, input logic [15:0] pc, op, et, input logic [7:0] oc, eo);
        jmp_kind = k;
        next_pc = pc;
        jmp_operand = op;
        opcode_in = oc;
        tick;
        chk(jmp_target, et);
        chk(16'(opcode_out), 16'(eo));
    endtask

    task automatic t_data;
        dacc(4'h0, 3'h0, 8'h81, 8'h00);
        chk(16'(rd), 16'h0007);
        dacc(4'h8, 3'h0, 8'h00, 8'h90);
        dacc(4'hC, 3'h0, 8'h00, 8'hA7);
        dacc(4'h4, 3'h0, 8'h00, 8'h00);
        chk({7'h00, sel, rd}, 16'h00A7);
        dacc(4'h0, 3'h0, 8'h90, 8'h00);
        chk({7'h00, sel, rd}, 16'h0109);
        dacc(4'h8, 3'h0, 8'h45, 8'h6E);
        dacc(4'h8, 3'h0, 8'h01, 8'h45);
        dacc(4'h4, 3'h1, 8'h00, 8'h00);
        chk(16'(rd), 16'h006E);
        dacc(4'h8, 3'h0, 8'h1A, 8'h3C);
        dacc(4'h8, 3'h0, 8'hD0, 8'h18);
        dacc(4'h2, 3'h2, 8'h00, 8'h00);
        chk(16'(rd), 16'h003C);
        dacc(4'h8, 3'h0, 8'hD0, 8'h00);
        dacc(4'h8, 3'h0, 8'h22, 8'h08);
        dacc(4'h1, 3'h0, 8'h13, 8'h00);
        chk(16'(rd), 16'h0001);
        dacc(4'h1, 3'h0, 8'h12, 8'h00);
        chk(16'(rd), 16'h0000);
        dacc(4'h0, 3'h0, 8'h22, 8'h00);
        chk(16'(rd), 16'h0008);
        dreq = '0;
    endtask
    task automatic t_branch;
        br(CMAS_JMP_REL, 16'h1000, 16'h00FE, 16'h0FFE, 8'hA5, 8'h00);
        br(CMAS_JMP_REL, 16'h1000, 16'h007F, 16'h107F, 8'h74, 8'h74);
        br(CMAS_JMP_ABS, 16'h3800, 16'hFFFF, 16'h3FFF, 8'hA5, 8'h00);
        br(CMAS_JMP_LONG, 16'h2000, 16'hBEEF, 16'hBEEF, 8'h00, 8'h00);
    endtask
    task automatic t_prog;
        logic [15:0] pa [7] = '{16'h0000, 16'h7DFF, 16'h7E00, 16'h7FFF, 16'h8000, 16'h807F, 16'h8080};
        logic        ph [7] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
        for (int i = 0; i < 7; i++) begin
            prog_addr = pa[i];
            tick;
            chk(16'(prog_hit), 16'(ph[i]));
        end
        prog_addr = 16'h1000;
        ext_move_wr = 1'b1;
        tick;
        chk(16'(prog_wr_en), 16'h0000);
        dacc(4'h8, 3'h0, 8'h8F, 8'h80);
        chk(16'(prog_wr_en), 16'h0001);
        dreq = '0;
    endtask
    task automatic t_stack;
        reset_dut;
        sop(6'b010000, 8'h00);
        chk(16'(rec_underflow), 16'h0001);
        reset_dut;
        sop(6'b100000, 8'hC3);
        chk(16'(stack_pointer), 16'h0008);
        sop(6'b100000, 8'h3C);
        sop(6'b010000, 8'h00);
        chk(16'(pop_data), 16'h003C);
        sop(6'b010000, 8'h00);
        chk({pop_data, stack_pointer}, 16'hC307);
        repeat (16) sop(6'b000010, 8'h00);
        chk(16'(rec_overflow), 16'h0000);
        sop(6'b100000, 8'h11);
        chk(16'(rec_overflow), 16'h0001);
        sop(6'b000000, 8'h00);
        dacc(4'h8, 3'h0, 8'h81, 8'hFF);
        dreq = '0;
        sop(6'b100000, 8'h22);
        chk(16'(stack_pointer), 16'h0000);
        clk_en = 1'b0;
        sop(6'b010000, 8'h00);
        clk_en = 1'b1;
        sop(6'b010000, 8'h00);
        chk(16'(stack_pointer), 16'h00FF);
        sop(6'b000000, 8'h00);
    endtask

    // Whole run is under a hundred cycles; the limit leaves ample margin
    initial begin
        repeat (3000) @(posedge ref_clk);
        err_count++;
        end_sim;
    end
    initial begin
        reset_dut;
        t_data;
        t_branch;
        t_prog;
        t_stack;
        end_sim;
    end
endmodule
`default_nettype wire
